// file: ams_sequencer.sv
/*
  operating-mode and update-rate sequencer of a sigma-delta converter:
  mode word, conversion and calibration sequencing, ready flag, result
  and coefficient storage, serial result output and clock selection.
  assumes host strobes are one-cycle pulses on clk_sys; sclk_pin and
  ext_clk_pin are asynchronous pins; filter_result is same-domain.
*/
module ams_sequencer #(
  parameter int MOD_DIV = ams_pkg::MOD_DIV_CYC
) (
  // clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  // host commands
  input  wire logic                        mode_wr,
  input  wire logic [15:0]                 mode_wdata,
  input  wire logic                        cfg_wr,
  input  wire logic                        chan_change,
  input  wire logic                        rd_cmd,
  input  wire logic                        cont_read,
  // pins
  input  wire logic                        sclk_pin,
  input  wire logic                        ext_clk_pin,
  output logic                             dout,
  output logic                             clk_pin_o,
  output logic                             clk_pin_oe,
  // converter core
  input  wire logic [ams_pkg::DATA_W-1:0]  filter_result,
  input  wire logic                        burnout_req,
  output logic                             filter_rst,
  output logic                             mod_clk_run,
  output logic                             cal_short,
  output logic                             analog_on,
  output logic                             burnout_en,
  // status
  output logic [15:0]                      mode_q,
  output logic                             rdy_n,
  output logic [ams_pkg::DATA_W-1:0]       data_q,
  output logic [ams_pkg::DATA_W-1:0]       offset_q,
  output logic [ams_pkg::DATA_W-1:0]       fullscale_q,
  output logic [ams_pkg::SETTLE_W-1:0]     settle_ms
);

  // ==========================================================
  // state
  typedef enum logic [1:0] {
    ST_RUN  = 2'h0,
    ST_WARM = 2'h1,
    ST_IDLE = 2'h2,
    ST_DOWN = 2'h3
  } ams_seq_t;

  typedef struct packed {
    logic [15:0]                    mode_reg;
    ams_seq_t                       st;
    logic                           first;
    logic [6:0]                     warm_cnt;
    logic [10:0]                    div_cnt;
    logic                           int_clk;
    logic                           ext_s1;
    logic                           ext_s2;
    logic                           ext_s3;
    logic                           ext_half;
    logic                           sclk_s1;
    logic                           sclk_s2;
    logic                           sclk_s3;
    logic [ams_pkg::DATA_W-1:0]     data;
    logic [ams_pkg::DATA_W-1:0]     offset;
    logic [ams_pkg::DATA_W-1:0]     gain;
    logic [ams_pkg::DATA_W-1:0]     shift;
    logic [4:0]                     bit_cnt;
    logic                           shifting;
    logic                           dout;
    logic                           rdy_n;
    logic                           filter_rst;
    logic                           mod_clk_run;
    logic                           cal_short;
    logic                           analog_on;
    logic                           burnout_en;
    logic                           clk_o;
    logic                           clk_oe;
    logic [ams_pkg::SETTLE_W-1:0]   settle;
  } ams_seq_state_t;

  localparam logic [10:0] DIV_LAST  = 11'(MOD_DIV - 1);
  localparam logic [10:0] DIV_HALF  = 11'(MOD_DIV / 2);
  localparam logic [6:0]  WARM_LAST = 7'(ams_pkg::OSC_SETTLE_TICKS - 1);
  localparam logic [4:0]  BITS_LAST = 5'(ams_pkg::DATA_W - 1);

  ams_seq_state_t        s_reg;
  ams_seq_state_t        s_next;
  logic                  tick;
  logic                  restart;
  logic                  period_done;
  logic                  complete;
  ams_pkg::ams_op_mode_t op_mode;

  // ==========================================================
  // period timer
  ams_rate_timer u_timer (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .tick        (tick),
    .run         (s_reg.st == ST_RUN),
    .restart     (restart),
    .rate_code   (s_reg.mode_reg[ams_pkg::RATE_MSB:ams_pkg::RATE_LSB]),
    .period_done (period_done)
  );

  // ==========================================================
  // next state
  always_comb
  begin
    s_next   = s_reg;
    complete = 1'b0;
    op_mode  = ams_pkg::ams_op_mode_t'(
                 s_reg.mode_reg[ams_pkg::MODE_MSB:ams_pkg::MODE_LSB]);
    // pin synchronisers
    s_next.ext_s1  = ext_clk_pin;
    s_next.ext_s2  = s_reg.ext_s1;
    s_next.ext_s3  = s_reg.ext_s2;
    s_next.sclk_s1 = sclk_pin;
    s_next.sclk_s2 = s_reg.sclk_s1;
    s_next.sclk_s3 = s_reg.sclk_s2;
    // internal 64 kHz divider
    if (s_reg.div_cnt == DIV_LAST)
    begin
      s_next.div_cnt = '0;
    end
    else
    begin
      s_next.div_cnt = s_reg.div_cnt + 1'b1;
    end
    if (s_reg.div_cnt == '0 || s_reg.div_cnt == DIV_HALF)
    begin
      s_next.int_clk = ~s_reg.int_clk;
    end
    if (s_reg.ext_s2 && !s_reg.ext_s3)
    begin
      s_next.ext_half = ~s_reg.ext_half;
    end
    case (ams_pkg::ams_clk_src_t'(
            s_reg.mode_reg[ams_pkg::CSRC_MSB:ams_pkg::CSRC_LSB]))
      ams_pkg::AMS_CS_EXT:     tick = s_reg.ext_s2 && !s_reg.ext_s3;
      ams_pkg::AMS_CS_EXT_DIV: tick = s_reg.ext_s2 && !s_reg.ext_s3 &&
                                      s_reg.ext_half;
      default:                 tick = (s_reg.div_cnt == DIV_LAST);
    endcase
    restart = mode_wr ||
              ((cfg_wr || chan_change) && s_reg.st == ST_RUN);

    // serial result output, data changes on sclk falling edge
    if (rd_cmd && !cont_read)
    begin
      s_next.shift    = s_reg.data << 1;
      s_next.dout     = s_reg.data[ams_pkg::DATA_W-1];
      s_next.bit_cnt  = BITS_LAST;
      s_next.shifting = 1'b1;
    end
    else if (s_reg.shifting && !s_reg.sclk_s2 && s_reg.sclk_s3)
    begin
      if (s_reg.bit_cnt == '0)
      begin
        s_next.shifting = 1'b0;
        s_next.rdy_n    = 1'b1;
      end
      else
      begin
        s_next.dout    = s_reg.shift[ams_pkg::DATA_W-1];
        s_next.shift   = s_reg.shift << 1;
        s_next.bit_cnt = s_reg.bit_cnt - 1'b1;
      end
    end

    if (mode_wr)
    begin
      s_next.mode_reg = mode_wdata;
      s_next.rdy_n    = 1'b1;
      s_next.first    = 1'b1;
      s_next.warm_cnt = '0;
      case (ams_pkg::ams_op_mode_t'(
              mode_wdata[ams_pkg::MODE_MSB:ams_pkg::MODE_LSB]))
        ams_pkg::AMS_OP_CONT:   s_next.st = ST_RUN;
        ams_pkg::AMS_OP_SINGLE: s_next.st = ST_WARM;
        ams_pkg::AMS_OP_IDLE:   s_next.st = ST_IDLE;
        ams_pkg::AMS_OP_DOWN:   s_next.st = ST_DOWN;
        ams_pkg::AMS_OP_RSVD:   s_next.st = ST_IDLE;
        default:                s_next.st = ST_RUN;
      endcase
    end
    else if (restart)
    begin
      s_next.first = 1'b1;
    end
    else
    begin
      case (s_reg.st)
        ST_WARM:
        begin
          if (tick)
          begin
            if (s_reg.warm_cnt == WARM_LAST)
            begin
              s_next.st    = ST_RUN;
              s_next.first = 1'b1;
            end
            else
            begin
              s_next.warm_cnt = s_reg.warm_cnt + 1'b1;
            end
          end
        end
        ST_RUN:
        begin
          if (period_done)
          begin
            s_next.first = 1'b0;
            complete     = !s_reg.first;
          end
        end
        default:
        begin
        end
      endcase
    end

    if (complete)
    begin
      s_next.rdy_n = 1'b0;
      case (op_mode)
        ams_pkg::AMS_OP_CONT:
        begin
          s_next.data = filter_result;
          if (cont_read)
          begin
            s_next.shift    = filter_result << 1;
            s_next.dout     = filter_result[ams_pkg::DATA_W-1];
            s_next.bit_cnt  = BITS_LAST;
            s_next.shifting = 1'b1;
          end
        end
        ams_pkg::AMS_OP_SINGLE:
        begin
          s_next.data = filter_result;
          s_next.st   = ST_DOWN;
        end
        ams_pkg::AMS_OP_FC_SYS:
        begin
          s_next.gain = filter_result;
          s_next.st   = ST_IDLE;
          s_next.mode_reg[ams_pkg::MODE_MSB:ams_pkg::MODE_LSB] =
            ams_pkg::AMS_OP_IDLE;
        end
        default:
        begin
          s_next.offset = filter_result;
          s_next.st     = ST_IDLE;
          s_next.mode_reg[ams_pkg::MODE_MSB:ams_pkg::MODE_LSB] =
            ams_pkg::AMS_OP_IDLE;
        end
      endcase
    end

    // analog controls follow the next state
    s_next.filter_rst  = (s_next.st != ST_RUN) || restart;
    s_next.mod_clk_run = (s_next.st != ST_DOWN);
    s_next.analog_on   = (s_next.st != ST_DOWN);
    s_next.burnout_en  = burnout_req && (s_next.st != ST_DOWN);
    s_next.cal_short   = (s_next.st == ST_RUN) &&
      (s_next.mode_reg[ams_pkg::MODE_MSB:ams_pkg::MODE_LSB] ==
       ams_pkg::AMS_OP_ZC_INT);
    s_next.clk_oe      = (s_next.st != ST_DOWN) &&
      (s_next.mode_reg[ams_pkg::CSRC_MSB:ams_pkg::CSRC_LSB] ==
       ams_pkg::AMS_CS_INT_OUT);
    s_next.clk_o       = s_next.clk_oe && s_next.int_clk;
    s_next.settle      = ams_pkg::ams_settle_ms(
      s_next.mode_reg[ams_pkg::RATE_MSB:ams_pkg::RATE_LSB]);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s_reg             <= '0;
      s_reg.mode_reg    <= ams_pkg::MODE_RST;
      s_reg.st          <= ST_RUN;
      s_reg.first       <= 1'b1;
      s_reg.rdy_n       <= 1'b1;
      s_reg.filter_rst  <= 1'b1;
      s_reg.mod_clk_run <= 1'b1;
      s_reg.analog_on   <= 1'b1;
      s_reg.settle      <= ams_pkg::SETTLE_16P7;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // outputs
  assign dout        = s_reg.dout;
  assign clk_pin_o   = s_reg.clk_o;
  assign clk_pin_oe  = s_reg.clk_oe;
  assign filter_rst  = s_reg.filter_rst;
  assign mod_clk_run = s_reg.mod_clk_run;
  assign cal_short   = s_reg.cal_short;
  assign analog_on   = s_reg.analog_on;
  assign burnout_en  = s_reg.burnout_en;
  assign mode_q      = s_reg.mode_reg;
  assign rdy_n       = s_reg.rdy_n;
  assign data_q      = s_reg.data;
  assign offset_q    = s_reg.offset;
  assign fullscale_q = s_reg.gain;
  assign settle_ms   = s_reg.settle;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_reset_mode;
    $fell(rst) |-> mode_q == ams_pkg::MODE_RST && s_reg.st == ST_RUN;
  endproperty
  a_reset_mode: assert property (p_reset_mode)
    else $error("mode word not at reset value after reset");

  property p_cont_result;
    complete && op_mode == ams_pkg::AMS_OP_CONT
      |=> data_q == $past(filter_result) && !rdy_n;
  endproperty
  a_cont_result: assert property (p_cont_result)
    else $error("continuous result not stored or ready not low");

  property p_cont_read;
    complete && op_mode == ams_pkg::AMS_OP_CONT && cont_read
      |=> dout == $past(filter_result[ams_pkg::DATA_W-1]) && s_reg.shifting;
  endproperty
  a_cont_read: assert property (p_cont_read)
    else $error("continuous read did not load the result");

  property p_first_skip;
    s_reg.st == ST_RUN && s_reg.first && period_done && !restart
      |-> !complete ##1 !s_reg.first;
  endproperty
  a_first_skip: assert property (p_first_skip)
    else $error("first period produced a result");

  property p_warm_done;
    s_reg.st == ST_WARM && tick && s_reg.warm_cnt == WARM_LAST && !mode_wr
      |=> s_reg.st == ST_RUN && s_reg.first;
  endproperty
  a_warm_done: assert property (p_warm_done)
    else $error("settling wait did not end in conversion");

  property p_single_down;
    complete && op_mode == ams_pkg::AMS_OP_SINGLE
      |=> s_reg.st == ST_DOWN && !rdy_n && !analog_on;
  endproperty
  a_single_down: assert property (p_single_down)
    else $error("single conversion did not power down");

  property p_idle_hold;
    s_reg.st == ST_IDLE |-> filter_rst && mod_clk_run;
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("idle does not hold filter with clocks running");

  property p_down_off;
    s_reg.st == ST_DOWN |-> !analog_on && !burnout_en && !clk_pin_oe;
  endproperty
  a_down_off: assert property (p_down_off)
    else $error("power-down left a circuit on");

  property p_cal_end;
    complete && op_mode[2]
      |=> !rdy_n && mode_q[ams_pkg::MODE_MSB:ams_pkg::MODE_LSB] ==
          ams_pkg::AMS_OP_IDLE && s_reg.st == ST_IDLE;
  endproperty
  a_cal_end: assert property (p_cal_end)
    else $error("calibration did not end in idle with ready low");

  property p_zero_cal;
    complete && op_mode == ams_pkg::AMS_OP_ZC_SYS
      |=> offset_q == $past(filter_result);
  endproperty
  a_zero_cal: assert property (p_zero_cal)
    else $error("offset coefficient not stored");

  property p_mode_write;
    mode_wr |=> rdy_n && filter_rst && mode_q == $past(mode_wdata);
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("mode write did not restart conversion");

  c_cont_done:   cover property (complete && op_mode == ams_pkg::AMS_OP_CONT);
  c_single_done: cover property (complete && op_mode ==
                                 ams_pkg::AMS_OP_SINGLE);
  c_cal_done:    cover property (complete && op_mode[2]);
  c_read_done:   cover property (s_reg.shifting ##1 !s_reg.shifting);

endmodule

// file: ams_pkg.sv
/*
  constants, types and lookup functions for the converter mode and
  update-rate sequencer.
  assumes a single 100 MHz system clock; rates are counted in ticks of
  the 64 kHz converter clock.
*/
// Notes on behaviour
// - after reset the mode field selects continuous conversion
// - continuous mode converts back to back, stores result, drives ready low
// - continuous read shifts each new result out on serial clock pulses
// - otherwise a read command loads the data register onto serial output
// - after restart first result takes two periods, then one per period
// - single mode: wake, settle 1 ms, convert two periods, then power down
// - single result and low ready stay until read or next conversion
// - idle holds filter and modulator reset while modulator clocks run
// - power-down turns off all circuits, burnout sources and clock driver
// - internal zero-scale shorts input, two cycles, stores offset coefficient
// - calibration drives ready high at start and low at finish
// - a finished calibration switches the mode to idle by itself
// - system zero-scale measures two cycles, stores offset coefficient
// - system full-scale measures two cycles, stores gain coefficient
// - codes 3,4,5,7 give 123, 62, 50, 33.2 Hz; 16..60 ms settling
// - codes 9 and 10 give 16.7 Hz and 120 ms settling
// - codes 11 to 15 give 12.5 down to 4.17 Hz, 160 to 480 ms
// - any mode write resets modulator and filter and sets ready high
// - mode word is 16 bits, msb first, reset 0x000a, fields as given
// - clock source: internal, internal driven out, external, external/2
package ams_pkg;

  // ==========================================================
  // clocks and times
  localparam int CLK_HZ           = 100_000_000;
  localparam int MCLK_HZ          = 64_000;
  localparam int MCLK_CHZ         = MCLK_HZ * 100;
  localparam int MOD_DIV_CYC      = CLK_HZ / MCLK_HZ;
  localparam int OSC_SETTLE_US    = 1000;
  localparam int OSC_SETTLE_TICKS =
    (OSC_SETTLE_US * MCLK_HZ + 999_999) / 1_000_000;

  // ==========================================================
  // mode word layout
  localparam logic [15:0] MODE_RST  = 16'h000a;
  localparam int          MODE_MSB  = 15;
  localparam int          MODE_LSB  = 13;
  localparam int          CSRC_MSB  = 7;
  localparam int          CSRC_LSB  = 6;
  localparam int          RATE_MSB  = 3;
  localparam int          RATE_LSB  = 0;
  localparam int          DATA_W    = 24;
  localparam int          PERIOD_W  = 14;
  localparam int          SETTLE_W  = 9;

  typedef enum logic [2:0] {
    AMS_OP_CONT   = 3'h0,
    AMS_OP_SINGLE = 3'h1,
    AMS_OP_IDLE   = 3'h2,
    AMS_OP_DOWN   = 3'h3,
    AMS_OP_ZC_INT = 3'h4,
    AMS_OP_RSVD   = 3'h5,
    AMS_OP_ZC_SYS = 3'h6,
    AMS_OP_FC_SYS = 3'h7
  } ams_op_mode_t;

  typedef enum logic [1:0] {
    AMS_CS_INT     = 2'h0,
    AMS_CS_INT_OUT = 2'h1,
    AMS_CS_EXT     = 2'h2,
    AMS_CS_EXT_DIV = 2'h3
  } ams_clk_src_t;

  // ==========================================================
  // update rates in centihertz and settling in milliseconds
  localparam int FADC_123  = 12300;
  localparam int FADC_62   = 6200;
  localparam int FADC_50   = 5000;
  localparam int FADC_33P2 = 3320;
  localparam int FADC_16P7 = 1670;
  localparam int FADC_12P5 = 1250;
  localparam int FADC_10   = 1000;
  localparam int FADC_8P33 = 833;
  localparam int FADC_6P25 = 625;
  localparam int FADC_4P17 = 417;
  localparam logic [8:0] SETTLE_123  = 9'd16;
  localparam logic [8:0] SETTLE_62   = 9'd32;
  localparam logic [8:0] SETTLE_50   = 9'd40;
  localparam logic [8:0] SETTLE_33P2 = 9'd60;
  localparam logic [8:0] SETTLE_16P7 = 9'd120;
  localparam logic [8:0] SETTLE_12P5 = 9'd160;
  localparam logic [8:0] SETTLE_10   = 9'd200;
  localparam logic [8:0] SETTLE_8P33 = 9'd240;
  localparam logic [8:0] SETTLE_6P25 = 9'd320;
  localparam logic [8:0] SETTLE_4P17 = 9'd480;

  // unlisted codes fall back to the 16.7 Hz reset rate
  function automatic int ams_rate_chz(input logic [3:0] code);
    case (code)
      4'h3:    return FADC_123;
      4'h4:    return FADC_62;
      4'h5:    return FADC_50;
      4'h7:    return FADC_33P2;
      4'h9:    return FADC_16P7;
      4'ha:    return FADC_16P7;
      4'hb:    return FADC_12P5;
      4'hc:    return FADC_10;
      4'hd:    return FADC_8P33;
      4'he:    return FADC_6P25;
      4'hf:    return FADC_4P17;
      default: return FADC_16P7;
    endcase
  endfunction

  function automatic logic [PERIOD_W-1:0] ams_rate_ticks(
    input logic [3:0] code);
    return PERIOD_W'(MCLK_CHZ / ams_rate_chz(code));
  endfunction

  function automatic logic [SETTLE_W-1:0] ams_settle_ms(
    input logic [3:0] code);
    case (code)
      4'h3:    return SETTLE_123;
      4'h4:    return SETTLE_62;
      4'h5:    return SETTLE_50;
      4'h7:    return SETTLE_33P2;
      4'h9:    return SETTLE_16P7;
      4'ha:    return SETTLE_16P7;
      4'hb:    return SETTLE_12P5;
      4'hc:    return SETTLE_10;
      4'hd:    return SETTLE_8P33;
      4'he:    return SETTLE_6P25;
      4'hf:    return SETTLE_4P17;
      default: return SETTLE_16P7;
    endcase
  endfunction

endpackage

// file: ams_rate_timer.sv
/*
  output-rate period timer: counts converter clock ticks and pulses
  once per update period of the selected rate code.
  assumes tick is a one-cycle enable on clk_sys.
*/
module ams_rate_timer (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // control
  input  wire logic       tick,
  input  wire logic       run,
  input  wire logic       restart,
  input  wire logic [3:0] rate_code,
  // event
  output logic            period_done
);

  typedef struct packed {
    logic [ams_pkg::PERIOD_W-1:0] cnt;
    logic                         done;
  } ams_tmr_state_t;

  ams_tmr_state_t s_reg;
  ams_tmr_state_t s_next;
  logic [ams_pkg::PERIOD_W-1:0] period;

  assign period      = ams_pkg::ams_rate_ticks(rate_code);
  assign period_done = s_reg.done;

  always_comb
  begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    if (!run || restart)
    begin
      s_next.cnt = '0;
    end
    else if (tick)
    begin
      if (s_reg.cnt == period - 1'b1)
      begin
        s_next.cnt  = '0;
        s_next.done = 1'b1;
      end
      else
      begin
        s_next.cnt = s_reg.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

endmodule

// file: ams_host.sv
/*
  host model: clocks one 24-bit word off the serial data line.
  assumes clk_sys from the bench; the serial clock idles high.
*/
module ams_host (
  // clock
  input  wire logic clk_sys,
  // serial pins
  input  wire logic dout,
  output logic      sclk_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  initial sclk_pin = 1'b1;

  // sample each bit before the falling edge that advances it
  task automatic read_word(output logic [23:0] w);
    repeat (8) @(negedge clk_sys);
    for (int i = 0; i < 24; i++)
    begin
      w = {w[22:0], dout};
      sclk_pin = 1'b0;
      repeat (8) @(negedge clk_sys);
      sclk_pin = 1'b1;
      repeat (8) @(negedge clk_sys);
    end
  endtask
endmodule

// file: ams_sequencer_tb.sv
/*
  testbench of the mode and rate sequencer with a host model.
  assumes a shortened converter clock divider of 4.
*/
module ams_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DIV = 4;
  localparam int PER = 520 * DIV;
  logic clk_sys = 0, rst = 1, mode_wr = 0, rd_cmd = 0, sclk_pin, dout;
  logic [15:0] mode_wdata = 16'h0000, mode_q;
  logic [23:0] res = 24'h5a3c96, w, data_q, offset_q, fullscale_q;
  logic [8:0] settle_ms;
  logic clk_pin_o, clk_pin_oe, filter_rst, mod_clk_run, cal_short;
  logic analog_on, burnout_en, rdy_n;
  int failures = 0, check_count = 0, cyc = 0, n, t0;
  int code[11] = '{3, 4, 5, 7, 9, 10, 11, 12, 13, 14, 15};
  int ms[11] = '{16, 32, 40, 60, 120, 120, 160, 200, 240, 320, 480};
  int cm[3] = '{4, 6, 7};
  logic chan_change = 0, cont_read = 0, burnout_req = 1, ck;

  ams_sequencer #(.MOD_DIV(DIV)) u_ams_sequencer (
    .clk_sys(clk_sys), .rst(rst), .mode_wr(mode_wr),
    .mode_wdata(mode_wdata), .cfg_wr(1'b0), .chan_change(chan_change),
    .rd_cmd(rd_cmd), .cont_read(cont_read), .sclk_pin(sclk_pin),
    .ext_clk_pin(1'b0), .dout(dout), .clk_pin_o(clk_pin_o),
    .clk_pin_oe(clk_pin_oe), .filter_result(res), .burnout_req(burnout_req),
    .filter_rst(filter_rst), .mod_clk_run(mod_clk_run),
    .cal_short(cal_short), .analog_on(analog_on),
    .burnout_en(burnout_en), .mode_q(mode_q), .rdy_n(rdy_n),
    .data_q(data_q), .offset_q(offset_q), .fullscale_q(fullscale_q),
    .settle_ms(settle_ms));
  ams_host u_ams_host (.clk_sys(clk_sys), .dout(dout),
    .sclk_pin(sclk_pin));

  always #5 clk_sys = ~clk_sys;

  task automatic summarize;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string s, input logic [23:0] e,
                     input logic [23:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask

  task automatic wr_mode(input logic [15:0] v);
    mode_wr = 1'b1;
    mode_wdata = v;
    @(negedge clk_sys);
    mode_wr = 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic wait_rdy(output int k);
    k = 0;
    while (rdy_n !== 1'b0 && k < 20000)
    begin
      @(negedge clk_sys);
      k++;
    end
  endtask

  // runaway guard
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 50000)
    begin
      failures++;
      summarize();
    end
  end

  initial
  begin
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    chk("mode_q", 24'h00000a, 24'(mode_q));
    chk("settle", 24'd120, 24'(settle_ms));
    foreach (code[i])
    begin
      wr_mode(16'(code[i]));
      chk("settle", 24'(ms[i]), 24'(settle_ms));
    end
    // continuous: first result after two periods, then one
    wr_mode(16'h0003);
    wait_rdy(n);
    t0 = cyc;
    chk("first", 24'h1, 24'(n > 2 * PER - 12 && n < 2 * PER + 8));
    chk("data", res, data_q);
    res = 24'hc3a5f0;
    rd_cmd = 1'b1;
    @(negedge clk_sys);
    rd_cmd = 1'b0;
    u_ams_host.read_word(w);
    chk("word", 24'h5a3c96, w);
    chk("rdy_n", 24'h1, 24'(rdy_n));
    wait_rdy(n);
    n = cyc - t0;
    chk("next", 24'h1, 24'(n > PER - 8 && n < PER + 8));
    chk("data", res, data_q);
    // continuous read, restarted by a mode write and a channel change
    cont_read = 1'b1;
    res = 24'h3c965a;
    wr_mode(16'h0003);
    wait_rdy(n);
    u_ams_host.read_word(w);
    chk("cread", res, w);
    res = 24'h69c3a5;
    chan_change = 1'b1;
    @(negedge clk_sys);
    chan_change = 1'b0;
    wait_rdy(n);
    chk("chan", 24'h1, 24'(n > 2 * PER - 12 && n < 2 * PER + 8));
    u_ams_host.read_word(w);
    chk("cread", res, w);
    cont_read = 1'b0;
    // single conversion, then power-down with the result held
    wr_mode(16'h2003);
    chk("rdy_n", 24'h1, 24'(rdy_n));
    wait_rdy(n);
    chk("single", 24'h1, 24'(n > 64 * DIV + 2 * PER - 12
      && n < 64 * DIV + 2 * PER + 8));
    repeat (50) @(negedge clk_sys);
    chk("analog", 24'h0, 24'(analog_on));
    chk("rdy_n", 24'h0, 24'(rdy_n));
    chk("data", res, data_q);
    foreach (cm[i])
    begin
      res = 24'(24'h111111 * (i + 2));
      wr_mode({3'(cm[i]), 13'h0003});
      chk("rdy_n", 24'h1, 24'(rdy_n));
      chk("short", 24'(cm[i] == 4), 24'(cal_short));
      wait_rdy(n);
      chk("cal", 24'h1, 24'(n > 2 * PER - 12 && n < 2 * PER + 8));
      repeat (2) @(negedge clk_sys);
      chk("mode", 24'h2, 24'(mode_q[15:13]));
      chk("coef", res, cm[i] == 7 ? fullscale_q : offset_q);
      chk("f_rst", 24'h1, 24'(filter_rst));
      chk("m_clk", 24'h1, 24'(mod_clk_run));
    end
    wr_mode(16'h0043);
    chk("clk_oe", 24'h1, 24'(clk_pin_oe));
    chk("burnout", 24'h1, 24'(burnout_en));
    ck = clk_pin_o;
    repeat (2) @(negedge clk_sys);
    chk("clk_o", 24'(!ck), 24'(clk_pin_o));
    wr_mode(16'h6043);
    repeat (2) @(negedge clk_sys);
    chk("clk_oe", 24'h0, 24'(clk_pin_oe));
    chk("analog", 24'h0, 24'(analog_on));
    chk("burnout", 24'h0, 24'(burnout_en));
    chk("clk_o", 24'h0, 24'(clk_pin_o));
    // reset again in mid-run, from power-down
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    chk("mode_q", 24'h00000a, 24'(mode_q));
    chk("analog", 24'h1, 24'(analog_on));
    summarize();
  end
endmodule
